// file: hdl/xlate_pkg.sv
// Constants and types of the translation front end.
// Assumes one clock domain and a single upstream port.
`default_nettype none
package xlate_pkg;
  localparam int VA_W      = 49;
  localparam int PA_W      = 48;
  localparam int PG_SH     = 12;
  localparam int VPN_W     = 37;
  localparam int PPN_W     = 36;
  localparam int L2_SH     = 21;
  localparam int L2T_W     = 28;
  localparam int UTLB_N    = 8;
  localparam int MAC_N     = 16;
  localparam int PF_N      = 16;
  localparam int WAYS      = 4;
  localparam int WC_N      = 8;
  localparam int IPA_N     = 8;
  localparam int MAX_WALKS = 8;
  localparam int WCNT_W    = 5;
  localparam int ID_W      = 4;
  localparam int DW        = 64;
  localparam int UW        = 4;
  localparam int AT_W      = 4;
  localparam int RA_W      = 4;
  localparam int CTRL_W    = 4;
  localparam logic [RA_W-1:0] REG_CTRL = 4'h0;
  localparam logic [RA_W-1:0] REG_STAT = 4'h4;
  localparam logic [RA_W-1:0] REG_HITS = 4'h8;
  localparam logic [RA_W-1:0] REG_MISS = 4'hC;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam int C_CANON  = 0;
  localparam int C_PF_EN  = 1;
  localparam int C_PF_64K = 2;
  localparam int C_IPA_EN = 3;
  localparam logic [VPN_W-1:0] STEP_4K  = 37'h1;
  localparam logic [VPN_W-1:0] STEP_64K = 37'h10;
  typedef enum logic [2:0] {
    ST_IDLE, ST_MICRO, ST_MACRO, ST_WALK, ST_WAIT, ST_SEND
  } front_state_t;
endpackage
`default_nettype wire

// file: hdl/translation_cache_bus_front.sv
// Translation front end: micro TLB, shared caches, bus ports, registers.
// Assumes inputs synchronous to clk_i and an external table walker.
// Operation
// - 49-bit input address, bit 48 selects range.
// - Output and snoop addresses are 48 bits.
// - Search micro TLB first, walk only on miss.
// - Micro TLB fully associative, entry count fixed.
// - Macro TLB caches completed walk results.
// - Prefetch next 4KB or 64KB page translation.
// - Prefetch buffer four-way, switchable, shares macro storage.
// - Walk cache holds level 2 entries, both stages.
// - Four-way INTERMEDIATE_PHYS_ADDRESS cache, switchable, shares walk storage.
// - Mode input only read back in status, operation same at either level.
// - Write data leave in write address order.
// - One lock bit, no locked transfers.
// - Attributes normalized only when enable bit set.
// - Only fields with stated reset are defined.
// - Reserved fields read zero, write zero.
// - Walk limit reached stops further acceptance.
//
// Strobed register access and the register offsets are this design's own decisions.
`default_nettype none
module translation_cache_bus_front (
  input  wire logic                         clk_i,
  input  wire logic                         rst_b_i,
  input  wire logic                         axi3_mode_i,
  input  wire logic                         ax_valid_i,
  output logic                              ax_ready_o,
  input  wire logic                         ax_write_i,
  input  wire logic [xlate_pkg::VA_W-1:0]   ax_addr_i,
  input  wire logic [xlate_pkg::ID_W-1:0]   ax_id_i,
  input  wire logic                         ax_lock_i,
  input  wire logic [xlate_pkg::AT_W-1:0]   ax_attr_i,
  output logic                              mx_valid_o,
  input  wire logic                         mx_ready_i,
  output logic                              mx_write_o,
  output logic [xlate_pkg::PA_W-1:0]        mx_addr_o,
  output logic [xlate_pkg::ID_W-1:0]        mx_id_o,
  output logic                              mx_lock_o,
  output logic [xlate_pkg::AT_W-1:0]        mx_attr_o,
  input  wire logic                         w_valid_i,
  output logic                              w_ready_o,
  input  wire logic [xlate_pkg::DW-1:0]     w_data_i,
  input  wire logic [xlate_pkg::UW-1:0]     w_user_i,
  input  wire logic                         w_last_i,
  output logic                              mw_valid_o,
  input  wire logic                         mw_ready_i,
  output logic [xlate_pkg::DW-1:0]          mw_data_o,
  output logic [xlate_pkg::UW-1:0]          mw_user_o,
  output logic                              mw_last_o,
  input  wire logic                         ac_valid_i,
  input  wire logic [xlate_pkg::PA_W-1:0]   ac_addr_i,
  output logic                              tw_req_valid_o,
  input  wire logic                         tw_req_ready_i,
  output logic                              tw_req_pf_o,
  output logic [xlate_pkg::VPN_W-1:0]       tw_req_vpn_o,
  output logic                              tw_req_l2_hit_o,
  output logic [xlate_pkg::PPN_W-1:0]       tw_req_l2_base_o,
  input  wire logic                         tw_resp_valid_i,
  input  wire logic                         tw_resp_pf_i,
  input  wire logic [xlate_pkg::VPN_W-1:0]  tw_resp_vpn_i,
  input  wire logic [xlate_pkg::PPN_W-1:0]  tw_resp_ppn_i,
  input  wire logic                         tw_resp_l2_valid_i,
  input  wire logic                         tw_resp_l2_stage2_i,
  input  wire logic [xlate_pkg::L2T_W-1:0]  tw_resp_l2_tag_i,
  input  wire logic [xlate_pkg::PPN_W-1:0]  tw_resp_l2_base_i,
  input  wire logic                         tw_resp_ipa_valid_i,
  input  wire logic [xlate_pkg::VPN_W-1:0]  tw_resp_ipa_vpn_i,
  input  wire logic [xlate_pkg::PPN_W-1:0]  tw_resp_ipa_ppn_i,
  input  wire logic                         q_valid_i,
  input  wire logic [xlate_pkg::VPN_W-1:0]  q_ipa_vpn_i,
  output logic                              q_ipa_hit_o,
  output logic                              q_l2_hit_o,
  output logic [xlate_pkg::PPN_W-1:0]       q_ppn_o,
  input  wire logic [xlate_pkg::RA_W-1:0]   reg_addr_i,
  input  wire logic [31:0]                  reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output logic [31:0]                       reg_rdata_o
);
  localparam int VW = xlate_pkg::VPN_W;
  localparam int PW = xlate_pkg::PPN_W;
  localparam int TN = xlate_pkg::MAC_N + xlate_pkg::PF_N;
  localparam int CN = xlate_pkg::WC_N + xlate_pkg::IPA_N;

  logic rst_meta_b, rst_sync_b;
  xlate_pkg::front_state_t state;
  logic [xlate_pkg::CTRL_W-1:0] ctrl;
  logic [31:0] hit_cnt, miss_cnt;
  logic [xlate_pkg::WCNT_W-1:0] walks_out;
  logic [8:0] wr_credit;
  logic [xlate_pkg::VA_W-1:0] req_addr;
  logic [xlate_pkg::ID_W-1:0] req_id;
  logic req_write, req_lock, pf_pending;
  logic [xlate_pkg::AT_W-1:0] req_attr, canon_attr;
  logic [VW-1:0] req_vpn, ut_vpn [xlate_pkg::UTLB_N];
  logic [PW-1:0] ut_ppn [xlate_pkg::UTLB_N];
  logic ut_vld [xlate_pkg::UTLB_N];
  logic [VW-1:0] tc_vpn [TN];
  logic [PW-1:0] tc_ppn [TN];
  logic tc_vld [TN];
  logic [VW-1:0] wc_tag [CN];
  logic [PW-1:0] wc_dat [CN];
  logic wc_vld [CN];
  logic wc_s2 [xlate_pkg::WC_N];
  logic [2:0] ut_ptr, wc_ptr;
  logic [3:0] mac_ptr;
  logic [1:0] way_ptr;
  logic ut_hit, tc_hit, wc_hit, qi_hit, ql_hit;
  logic [PW-1:0] ut_sel, tc_sel, wc_sel, qi_sel, ql_sel;
  logic ax_fire, tw_fire, mx_fire, w_fire, dem_resp, wlast_out;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  assign req_vpn = req_addr[xlate_pkg::VA_W-1:xlate_pkg::PG_SH];
  assign ax_ready_o = (state == xlate_pkg::ST_IDLE) &&
                      (walks_out < xlate_pkg::MAX_WALKS);
  assign ax_fire = ax_valid_i && ax_ready_o;
  assign tw_req_valid_o = (state == xlate_pkg::ST_WALK) ||
                          (state == xlate_pkg::ST_IDLE && pf_pending &&
                           walks_out < xlate_pkg::MAX_WALKS);
  assign tw_fire = tw_req_valid_o && tw_req_ready_i;
  assign mx_valid_o = (state == xlate_pkg::ST_SEND);
  assign mx_fire = mx_valid_o && mx_ready_i;
  assign dem_resp = tw_resp_valid_i && !tw_resp_pf_i &&
                    state == xlate_pkg::ST_WAIT;
  assign w_ready_o = (wr_credit != 9'h0) && (!mw_valid_o || mw_ready_i);
  assign w_fire = w_valid_i && w_ready_o;
  assign wlast_out = w_fire && w_last_i;

  // Attribute canonical form: cacheable lookups are made modifiable.
  always_comb begin
    canon_attr = req_attr;
    if (ctrl[xlate_pkg::C_CANON] && req_attr[3:2] != 2'h0) begin
      canon_attr[1] = 1'b1;
    end
  end

  always_comb begin
    int j;
    j = 0;
    ut_hit = 1'b0;
    ut_sel = '0;
    for (int i = 0; i < xlate_pkg::UTLB_N; i++) begin
      if (ut_vld[i] && ut_vpn[i] == req_vpn) begin
        ut_hit = 1'b1;
        ut_sel = ut_ppn[i];
      end
    end
    tc_hit = 1'b0;
    tc_sel = '0;
    for (int i = 0; i < xlate_pkg::MAC_N; i++) begin
      if (tc_vld[i] && tc_vpn[i] == req_vpn) begin
        tc_hit = 1'b1;
        tc_sel = tc_ppn[i];
      end
    end
    for (int w = 0; w < xlate_pkg::WAYS; w++) begin
      j = xlate_pkg::MAC_N + int'(req_vpn[1:0]) * xlate_pkg::WAYS + w;
      if (ctrl[xlate_pkg::C_PF_EN] && tc_vld[j] &&
          tc_vpn[j] == req_vpn) begin
        tc_hit = 1'b1;
        tc_sel = tc_ppn[j];
      end
    end
    wc_hit = 1'b0;
    wc_sel = '0;
    ql_hit = 1'b0;
    ql_sel = '0;
    for (int i = 0; i < xlate_pkg::WC_N; i++) begin
      if (wc_vld[i] && !wc_s2[i] &&
          wc_tag[i][xlate_pkg::L2T_W-1:0] == req_vpn[VW-1:9]) begin
        wc_hit = 1'b1;
        wc_sel = wc_dat[i];
      end
      if (wc_vld[i] && wc_s2[i] &&
          wc_tag[i][xlate_pkg::L2T_W-1:0] == q_ipa_vpn_i[VW-1:9]) begin
        ql_hit = 1'b1;
        ql_sel = wc_dat[i];
      end
    end
    qi_hit = 1'b0;
    qi_sel = '0;
    for (int w = 0; w < xlate_pkg::WAYS; w++) begin
      j = xlate_pkg::WC_N + int'(q_ipa_vpn_i[0]) * xlate_pkg::WAYS + w;
      if (ctrl[xlate_pkg::C_IPA_EN] && wc_vld[j] &&
          wc_tag[j] == q_ipa_vpn_i) begin
        qi_hit = 1'b1;
        qi_sel = wc_dat[j];
      end
    end
  end

  // Request sequencing: micro TLB, then shared caches, then a walk.
  always_ff @(posedge clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= xlate_pkg::ST_IDLE;
      req_addr <= '0;
      req_id <= '0;
      req_write <= 1'b0;
      req_lock <= 1'b0;
      req_attr <= '0;
      mx_addr_o <= '0;
      mx_write_o <= 1'b0;
      mx_id_o <= '0;
      mx_lock_o <= 1'b0;
      mx_attr_o <= '0;
      tw_req_vpn_o <= '0;
      tw_req_pf_o <= 1'b0;
      tw_req_l2_hit_o <= 1'b0;
      tw_req_l2_base_o <= '0;
      pf_pending <= 1'b0;
    end else begin
      case (state)
        xlate_pkg::ST_IDLE: begin
          if (tw_fire) begin
            pf_pending <= 1'b0;
          end
          if (ax_fire) begin
            req_addr <= ax_addr_i;
            req_id <= ax_id_i;
            req_write <= ax_write_i;
            req_lock <= ax_lock_i;
            req_attr <= ax_attr_i;
            state <= xlate_pkg::ST_MICRO;
          end
        end
        xlate_pkg::ST_MICRO: begin
          mx_write_o <= req_write;
          mx_id_o <= req_id;
          mx_lock_o <= req_lock;
          mx_attr_o <= canon_attr;
          mx_addr_o <= {ut_sel, req_addr[xlate_pkg::PG_SH-1:0]};
          state <= ut_hit ? xlate_pkg::ST_SEND
                          : xlate_pkg::ST_MACRO;
        end
        xlate_pkg::ST_MACRO: begin
          mx_addr_o <= {tc_sel, req_addr[xlate_pkg::PG_SH-1:0]};
          tw_req_vpn_o <= req_vpn;
          tw_req_pf_o <= 1'b0;
          tw_req_l2_hit_o <= wc_hit;
          tw_req_l2_base_o <= wc_sel;
          pf_pending <= 1'b0;
          state <= tc_hit ? xlate_pkg::ST_SEND
                          : xlate_pkg::ST_WALK;
        end
        xlate_pkg::ST_WALK: begin
          if (tw_fire) begin
            state <= xlate_pkg::ST_WAIT;
          end
        end
        xlate_pkg::ST_WAIT: begin
          if (dem_resp) begin
            mx_addr_o <= {tw_resp_ppn_i,
                          req_addr[xlate_pkg::PG_SH-1:0]};
            tw_req_pf_o <= 1'b1;
            tw_req_l2_hit_o <= 1'b0;
            tw_req_vpn_o <= req_vpn + (ctrl[xlate_pkg::C_PF_64K] ?
                            xlate_pkg::STEP_64K : xlate_pkg::STEP_4K);
            pf_pending <= ctrl[xlate_pkg::C_PF_EN];
            state <= xlate_pkg::ST_SEND;
          end
        end
        xlate_pkg::ST_SEND: begin
          if (mx_fire) begin
            state <= xlate_pkg::ST_IDLE;
          end
        end
        default: state <= xlate_pkg::ST_IDLE;
      endcase
    end
  end

  // Cache fills and snoop invalidation.
  always_ff @(posedge clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ut_ptr <= 3'h0;
      mac_ptr <= 4'h0;
      way_ptr <= 2'h0;
      wc_ptr <= 3'h0;
      for (int i = 0; i < xlate_pkg::UTLB_N; i++) begin
        ut_vld[i] <= 1'b0;
        ut_vpn[i] <= '0;
        ut_ppn[i] <= '0;
      end
      for (int i = 0; i < TN; i++) begin
        tc_vld[i] <= 1'b0;
        tc_vpn[i] <= '0;
        tc_ppn[i] <= '0;
      end
      for (int i = 0; i < CN; i++) begin
        wc_vld[i] <= 1'b0;
        wc_tag[i] <= '0;
        wc_dat[i] <= '0;
      end
      for (int i = 0; i < xlate_pkg::WC_N; i++) begin
        wc_s2[i] <= 1'b0;
      end
    end else begin
      if (ac_valid_i) begin
        for (int i = 0; i < xlate_pkg::UTLB_N; i++) begin
          if (ut_ppn[i] == ac_addr_i[xlate_pkg::PA_W-1:xlate_pkg::PG_SH]) begin
            ut_vld[i] <= 1'b0;
          end
        end
      end
      if ((state == xlate_pkg::ST_MACRO && tc_hit) || dem_resp) begin
        ut_vld[ut_ptr] <= 1'b1;
        ut_vpn[ut_ptr] <= req_vpn;
        ut_ppn[ut_ptr] <= dem_resp ? tw_resp_ppn_i : tc_sel;
        ut_ptr <= ut_ptr + 3'h1;
      end
      if (dem_resp) begin
        tc_vld[mac_ptr] <= 1'b1;
        tc_vpn[mac_ptr] <= tw_resp_vpn_i;
        tc_ppn[mac_ptr] <= tw_resp_ppn_i;
        mac_ptr <= mac_ptr + 4'h1;
      end
      if (tw_resp_valid_i && tw_resp_pf_i) begin
        tc_vld[xlate_pkg::MAC_N + int'(tw_resp_vpn_i[1:0]) * 4 +
               int'(way_ptr)] <= 1'b1;
        tc_vpn[xlate_pkg::MAC_N + int'(tw_resp_vpn_i[1:0]) * 4 +
               int'(way_ptr)] <= tw_resp_vpn_i;
        tc_ppn[xlate_pkg::MAC_N + int'(tw_resp_vpn_i[1:0]) * 4 +
               int'(way_ptr)] <= tw_resp_ppn_i;
        way_ptr <= way_ptr + 2'h1;
      end
      if (tw_resp_valid_i && tw_resp_l2_valid_i) begin
        wc_vld[wc_ptr] <= 1'b1;
        wc_s2[wc_ptr] <= tw_resp_l2_stage2_i;
        wc_tag[wc_ptr] <= {9'h0, tw_resp_l2_tag_i};
        wc_dat[wc_ptr] <= tw_resp_l2_base_i;
        wc_ptr <= wc_ptr + 3'h1;
      end
      if (tw_resp_valid_i && tw_resp_ipa_valid_i &&
          ctrl[xlate_pkg::C_IPA_EN]) begin
        wc_vld[xlate_pkg::WC_N + int'(tw_resp_ipa_vpn_i[0]) * 4 +
               int'(way_ptr)] <= 1'b1;
        wc_tag[xlate_pkg::WC_N + int'(tw_resp_ipa_vpn_i[0]) * 4 +
               int'(way_ptr)] <= tw_resp_ipa_vpn_i;
        wc_dat[xlate_pkg::WC_N + int'(tw_resp_ipa_vpn_i[0]) * 4 +
               int'(way_ptr)] <= tw_resp_ipa_ppn_i;
      end
    end
  end

  // Walk accounting, write data ordering, walker queries.
  always_ff @(posedge clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      walks_out <= '0;
      wr_credit <= 9'h0;
      mw_valid_o <= 1'b0;
      mw_data_o <= '0;
      mw_user_o <= '0;
      mw_last_o <= 1'b0;
      q_ipa_hit_o <= 1'b0;
      q_l2_hit_o <= 1'b0;
      q_ppn_o <= '0;
    end else begin
      walks_out <= walks_out + xlate_pkg::WCNT_W'(tw_fire)
                             - xlate_pkg::WCNT_W'(tw_resp_valid_i);
      wr_credit <= wr_credit + 9'(mx_fire && mx_write_o)
                             - 9'(wlast_out);
      if (w_fire) begin
        mw_valid_o <= 1'b1;
        mw_data_o <= w_data_i;
        mw_user_o <= w_user_i;
        mw_last_o <= w_last_i;
      end else if (mw_ready_i) begin
        mw_valid_o <= 1'b0;
      end
      if (q_valid_i) begin
        q_ipa_hit_o <= qi_hit;
        q_l2_hit_o <= ql_hit;
        q_ppn_o <= qi_hit ? qi_sel : ql_sel;
      end
    end
  end

  // Register port: control, status and counters.
  always_ff @(posedge clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl <= xlate_pkg::CTRL_RST;
      hit_cnt <= 32'h0;
      miss_cnt <= 32'h0;
      reg_rdata_o <= 32'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == xlate_pkg::REG_CTRL) begin
        ctrl <= reg_wdata_i[xlate_pkg::CTRL_W-1:0];
      end
      if (state == xlate_pkg::ST_MICRO) begin
        hit_cnt <= hit_cnt + 32'(ut_hit);
        miss_cnt <= miss_cnt + 32'(!ut_hit);
      end
      reg_rdata_o <= 32'h0;
      if (reg_rd_i) begin
        case (reg_addr_i)
          xlate_pkg::REG_CTRL: reg_rdata_o <= 32'(ctrl);
          xlate_pkg::REG_STAT: reg_rdata_o <= {22'h0, axi3_mode_i,
                                 pf_pending, state, walks_out};
          xlate_pkg::REG_HITS: reg_rdata_o <= hit_cnt;
          xlate_pkg::REG_MISS: reg_rdata_o <= miss_cnt;
          default: reg_rdata_o <= 32'h0;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_sync_b);

  walk_limit_a: assert property (walks_out >= xlate_pkg::MAX_WALKS
    |-> !ax_ready_o) else $error("accepted at walk limit");
  micro_first_a: assert property (state == xlate_pkg::ST_MICRO && ut_hit
    |=> mx_valid_o && !tw_req_valid_o) else $error("hit walked");
  walk_cause_a: assert property (tw_req_valid_o && !tw_req_pf_o
    |-> $past(state == xlate_pkg::ST_MACRO, 1) || state == xlate_pkg::ST_WALK)
    else $error("demand walk without miss");
  page_off_a: assert property (mx_valid_o |-> mx_addr_o[11:0]
    == req_addr[11:0]) else $error("page offset altered");
  wdata_order_a: assert property (w_fire |-> wr_credit != 9'h0)
    else $error("data before address");
  canon_off_a: assert property (mx_valid_o && !ctrl[xlate_pkg::C_CANON]
    |-> mx_attr_o == req_attr) else $error("attr changed");
  reserved_zero_a: assert property (reg_rd_i &&
    reg_addr_i == xlate_pkg::REG_CTRL |=> reg_rdata_o[31:4] == 28'h0)
    else $error("reserved bits set");
  pf_step_a: assert property (dem_resp && ctrl[xlate_pkg::C_PF_EN]
    && !ctrl[xlate_pkg::C_PF_64K] |=> pf_pending &&
    tw_req_vpn_o == $past(req_vpn) + 37'h1) else $error("bad prefetch");
  hit_path_c: cover property (state == xlate_pkg::ST_MICRO && ut_hit);
  walk_path_c: cover property (dem_resp ##[1:4] mx_fire);
  pf_fill_c: cover property (tw_resp_valid_i && tw_resp_pf_i);
  limit_c: cover property (walks_out == xlate_pkg::MAX_WALKS);
endmodule
`default_nettype wire

// file: tb/walker_model.sv
// Table walker and downstream ready source facing the translation front end.
// Assumes requests are held until taken and a single clock domain.
`default_nettype none
module walker_model (
  input  wire logic                        clk_i,
  input  wire logic                        rst_b_i,
  input  wire logic                        slow_i,
  input  wire logic                        req_valid_i,
  output logic                             req_ready_o,
  input  wire logic                        req_pf_i,
  input  wire logic [xlate_pkg::VPN_W-1:0] req_vpn_i,
  output logic                             resp_valid_o,
  output logic                             resp_pf_o,
  output logic [xlate_pkg::VPN_W-1:0]      resp_vpn_o,
  output logic [xlate_pkg::PPN_W-1:0]      resp_ppn_o,
  output logic                             mx_ready_o,
  output logic                             mw_ready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0]                  ph;
  logic                        busy;
  logic [3:0]                  cnt;
  logic                        pend_pf;
  logic [xlate_pkg::VPN_W-1:0] pend_vpn;
  int                          dem_cnt, pf_cnt;
  // Slow mode stalls walks and both downstream channels.
  assign req_ready_o = !busy && (!slow_i || ph == 2'h3);
  assign mx_ready_o  = !slow_i || ph[0];
  assign mw_ready_o  = !slow_i || ph[1];
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {ph, busy, cnt, pend_pf, pend_vpn} <= '0;
      {resp_valid_o, resp_pf_o, resp_vpn_o, resp_ppn_o} <= '0;
      dem_cnt <= 0;
      pf_cnt <= 0;
    end else begin
      ph <= ph + 2'h1;
      resp_valid_o <= 1'b0;
      // Released response fields do not keep their last value.
      {resp_pf_o, resp_vpn_o, resp_ppn_o} <=
        ~{resp_pf_o, resp_vpn_o, resp_ppn_o};
      if (req_valid_i && req_ready_o) begin
        busy <= 1'b1;
        cnt <= slow_i ? 4'h7 : 4'h1;
        pend_pf <= req_pf_i;
        pend_vpn <= req_vpn_i;
        if (req_pf_i) pf_cnt <= pf_cnt + 1;
        else dem_cnt <= dem_cnt + 1;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        resp_valid_o <= 1'b1;
        resp_pf_o <= pend_pf;
        resp_vpn_o <= pend_vpn;
        resp_ppn_o <= pend_vpn[35:0] ^ {35'h0, pend_vpn[36]} ^ 36'h5A5A5A5A5;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_translation_cache_bus_front.sv
// Bench of the translation front end: registers, lookups, walks, write data.
// Assumes the walker model on the far side of the walk port.
`default_nettype none
module tb_translation_cache_bus_front;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i, rst_b_i, axi3_mode_i, ax_valid_i, ax_ready_o;
  logic        ax_write_i, ax_lock_i, mx_valid_o, mx_ready_i, mx_write_o;
  logic        mx_lock_o, w_valid_i, w_ready_o, w_last_i, mw_valid_o;
  logic        mw_ready_i, mw_last_o, ac_valid_i, tw_req_valid_o, l2h;
  logic        tw_req_ready_i, tw_req_pf_o, tw_req_l2_hit_o, q_l2_hit_o;
  logic        tw_resp_valid_i, tw_resp_pf_i, tw_resp_l2_valid_i, slow;
  logic        tw_resp_l2_stage2_i, tw_resp_ipa_valid_i, q_valid_i;
  logic        q_ipa_hit_o, reg_wr_i, reg_rd_i;
  logic [48:0] ax_addr_i;
  logic [47:0] mx_addr_o, ac_addr_i;
  logic [3:0]  ax_id_i, ax_attr_i, mx_id_o, mx_attr_o, w_user_i, mw_user_o;
  logic [3:0]  reg_addr_i, at;
  logic [63:0] w_data_i, mw_data_o;
  logic [36:0] tw_req_vpn_o, tw_resp_vpn_i, tw_resp_ipa_vpn_i, q_ipa_vpn_i;
  logic [35:0] tw_req_l2_base_o, tw_resp_ppn_i, tw_resp_l2_base_i, l2b;
  logic [35:0] tw_resp_ipa_ppn_i, q_ppn_o;
  logic [27:0] tw_resp_l2_tag_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, rd;
  logic [68:0] mwq[$];
  int          errors = 0, cmp_count = 0, dem, i;
  assign ac_valid_i          = 1'b0;
  assign ac_addr_i           = 48'h0;
  assign tw_resp_l2_stage2_i = 1'b0;
  assign tw_resp_l2_valid_i  = tw_resp_valid_i;
  assign tw_resp_ipa_valid_i = tw_resp_valid_i;
  assign tw_resp_l2_tag_i    = tw_resp_vpn_i[36:9];
  assign tw_resp_l2_base_i   = {8'h00, tw_resp_vpn_i[36:9]};
  assign tw_resp_ipa_vpn_i   = tw_resp_vpn_i;
  assign tw_resp_ipa_ppn_i   = tw_resp_ppn_i;
  translation_cache_bus_front i_translation_cache_bus_front (.*);
  walker_model i_walker_model (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .slow_i       (slow),
    .req_valid_i  (tw_req_valid_o),
    .req_ready_o  (tw_req_ready_i),
    .req_pf_i     (tw_req_pf_o),
    .req_vpn_i    (tw_req_vpn_o),
    .resp_valid_o (tw_resp_valid_i),
    .resp_pf_o    (tw_resp_pf_i),
    .resp_vpn_o   (tw_resp_vpn_i),
    .resp_ppn_o   (tw_resp_ppn_i),
    .mx_ready_o   (mx_ready_i),
    .mw_ready_o   (mw_ready_i)
  );
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (mw_valid_o && mw_ready_i)
      mwq.push_back({mw_user_o, mw_last_o, mw_data_o});
    if (tw_req_valid_o && tw_req_ready_i)
      {l2h, l2b} <= {tw_req_l2_hit_o, tw_req_l2_base_o};
  end
  task automatic end_of_test();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bound(inout int n);
    n++;
    if (n > 300) begin
      errors++;
      $display("ERROR at %0t: wait limit reached", $time);
      end_of_test();
    end
  endtask
  function automatic logic [35:0] ppn(input logic [36:0] v);
    return v[35:0] ^ {35'h0, v[36]} ^ 36'h5A5A5A5A5;
  endfunction
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic reg_read(input logic [3:0] a);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    rd = reg_rdata_o;
  endtask
  task automatic xlate(input logic wr, input logic [48:0] a,
                       input logic [3:0] id, input logic [3:0] atr);
    int n;
    ax_valid_i <= 1'b1;
    ax_write_i <= wr;
    ax_addr_i <= a;
    ax_id_i <= id;
    ax_attr_i <= atr;
    n = 0;
    do begin @(posedge clk_i); bound(n); end while (!ax_ready_o);
    ax_valid_i <= 1'b0;
    n = 0;
    do begin @(posedge clk_i); bound(n); end
    while (!(mx_valid_o && mx_ready_i));
    at = mx_attr_o;
    check({mx_write_o, mx_lock_o, mx_id_o}, {wr, 1'b0, id});
    check(mx_addr_o, {ppn(a[48:12]), a[11:0]});
  endtask
  task automatic beat(input logic [3:0] u, input logic l,
                      input logic [63:0] d);
    int n;
    w_valid_i <= 1'b1;
    w_user_i <= u;
    w_last_i <= l;
    w_data_i <= d;
    n = 0;
    do begin @(posedge clk_i); bound(n); end while (!w_ready_o);
  endtask
  task automatic query(input logic [36:0] v, input logic hit);
    q_valid_i <= 1'b1;
    q_ipa_vpn_i <= v;
    @(posedge clk_i);
    q_valid_i <= 1'b0;
    @(posedge clk_i);
    check({q_ipa_hit_o, q_l2_hit_o}, {hit, 1'b0});
    if (hit) check(q_ppn_o, ppn(v));
  endtask
  initial begin
    {rst_b_i, axi3_mode_i, ax_valid_i, ax_write_i, ax_lock_i, slow} = '0;
    {w_valid_i, w_last_i, q_valid_i, reg_wr_i, reg_rd_i} = '0;
    {ax_addr_i, ax_id_i, ax_attr_i, w_user_i, reg_addr_i} = '0;
    {w_data_i, q_ipa_vpn_i, reg_wdata_i} = '0;
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    axi3_mode_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reg_read(xlate_pkg::REG_CTRL);
    check(rd, 32'h0);
    reg_write(xlate_pkg::REG_CTRL, 32'h0000000F);
    reg_write(xlate_pkg::REG_STAT, 32'hFFFFFFFF);
    reg_write(4'h2, 32'hFFFFFFFF);
    reg_read(xlate_pkg::REG_CTRL);
    check(rd, 32'h0000000F);
    reg_write(xlate_pkg::REG_CTRL, 32'h0);
    reg_read(4'h2);
    check(rd, 32'h0);
    reg_read(xlate_pkg::REG_STAT);
    check(rd, 32'h00000200);
    xlate(1'b0, 49'h0_0000_1234_5678, 4'h1, 4'h4);
    check(at, 4'h4);
    xlate(1'b0, 49'h0_0000_1234_5ABC, 4'h2, 4'h4);
    check(i_walker_model.dem_cnt, 1);
    xlate(1'b0, 49'h1_0000_1234_5678, 4'h3, 4'h4);
    check(i_walker_model.dem_cnt, 2);
    check(i_walker_model.pf_cnt, 0);
    reg_read(xlate_pkg::REG_HITS);
    check(rd, 32'h1);
    reg_read(xlate_pkg::REG_MISS);
    check(rd, 32'h2);
    reg_write(xlate_pkg::REG_CTRL, 32'h1);
    xlate(1'b0, 49'h0_0000_1234_5000, 4'h4, 4'h4);
    check(at, 4'h6);
    xlate(1'b0, 49'h0_0000_1234_5000, 4'h5, 4'h1);
    check(at, 4'h1);
    slow <= 1'b1;
    for (i = 1; i < 10; i++) begin
      xlate(1'b0, 49'h0_0000_2000_0000 + 49'(i) * 49'h1000, 4'h6, 4'h0);
      check(l2h, i > 1);
      if (i > 1) check(l2b, 36'h100);
    end
    dem = i_walker_model.dem_cnt;
    xlate(1'b0, 49'h0_0000_1234_5678, 4'h7, 4'h0);
    check(i_walker_model.dem_cnt, dem);
    slow <= 1'b0;
    reg_write(xlate_pkg::REG_CTRL, 32'h2);
    xlate(1'b0, 49'h0_0005_0000_0000, 4'h8, 4'h0);
    i = 0;
    do begin @(posedge clk_i); bound(i); end
    while (i_walker_model.pf_cnt < 1 || i_walker_model.busy);
    check(i_walker_model.pend_vpn, 37'h0_0050_0001);
    dem = i_walker_model.dem_cnt;
    xlate(1'b0, 49'h0_0005_0000_1000, 4'h9, 4'h0);
    check(i_walker_model.dem_cnt, dem);
    reg_write(xlate_pkg::REG_CTRL, 32'h6);
    xlate(1'b0, 49'h0_0006_0000_0000, 4'hA, 4'h0);
    i = 0;
    do begin @(posedge clk_i); bound(i); end
    while (i_walker_model.pf_cnt < 2 || i_walker_model.busy);
    check(i_walker_model.pend_vpn, 37'h0_0060_0010);
    reg_write(xlate_pkg::REG_CTRL, 32'h8);
    xlate(1'b0, 49'h0_0007_0000_0000, 4'hB, 4'h0);
    query(37'h0_0070_0000, 1'b1);
    query(37'h0_0050_0000, 1'b0);
    slow <= 1'b1;
    xlate(1'b1, 49'h0_0008_0000_0000, 4'h3, 4'h0);
    xlate(1'b1, 49'h0_0009_0000_0000, 4'h5, 4'h0);
    // Data beats follow the order of their addresses.
    beat(4'h3, 1'b0, 64'h11);
    beat(4'h3, 1'b1, 64'h22);
    beat(4'h5, 1'b1, 64'h33);
    w_valid_i <= 1'b0;
    i = 0;
    do begin @(posedge clk_i); bound(i); end while (mwq.size() < 3);
    check(mwq[0], {4'h3, 1'b0, 64'h11});
    check(mwq[1], {4'h3, 1'b1, 64'h22});
    check(mwq[2], {4'h5, 1'b1, 64'h33});
    end_of_test();
  end
endmodule
`default_nettype wire
